// File: common/swsc_params.svh
// Constants for the sleep, wake and scan controller.
`ifndef SWSC_PARAMS_SVH
`define SWSC_PARAMS_SVH
`define SWSC_CLK_HZ        10000000
`define SWSC_N_IN          22
`define SWSC_N_PROG        8
`define SWSC_N_GND         14
`define SWSC_WORD_W        24
`define SWSC_THERM_BIT     23
`define SWSC_INT_BIT       22
`define SWSC_OP_W          8
`define SWSC_OP_STATUS     8'h00
`define SWSC_OP_SLEEP      8'h0C
`define SWSC_INT_CODE_LSB  3
`define SWSC_SCAN_CODE_LSB 0
`define SWSC_INT_OFF_CODE  3'h7
`define SWSC_SCAN_OFF_CODE 3'h0
`define SWSC_INT_BASE_MS   32
`define SWSC_SCAN_BASE_US  1000
`define SWSC_SCAN_WIN_US   125
`define SWSC_WET_MS        20
`define SWSC_US_CYC        (`SWSC_CLK_HZ / 1000000)
`define SWSC_INT_BASE_CYC  (`SWSC_INT_BASE_MS * 1000 * `SWSC_US_CYC)
`define SWSC_SCAN_BASE_CYC (`SWSC_SCAN_BASE_US * `SWSC_US_CYC)
`define SWSC_SCAN_WIN_CYC  (`SWSC_SCAN_WIN_US * `SWSC_US_CYC)
`define SWSC_WET_CYC       (`SWSC_WET_MS * 1000 * `SWSC_US_CYC)
`endif

// File: common/swsc_pkg.sv
// Types shared by the sleep, wake and scan controller.
package swsc_pkg;
  typedef enum logic [1:0] {
    SWSC_NORMAL = 2'b00,
    SWSC_SLEEP  = 2'b01,
    SWSC_SCAN   = 2'b10
  } swsc_mode_e;

  // Per-input configuration kept across sleep.
  typedef struct packed {
    logic [21:0] wake_en;
    logic [21:0] metallic;
    logic [21:0] wet_timer_en;
    logic [21:0] tristate;
  } swsc_cfg_s;

  // Current drive per input.
  typedef struct packed {
    logic [21:0] high;
    logic [21:0] low;
    logic [21:0] tristate;
  } swsc_drive_s;
endpackage

// File: design/swsc_ctrl.sv
// Mode, wake, scan, thermal and interrupt control for a switch interface.
`timescale 1ns/1ns
`default_nettype none
`include "swsc_params.svh"
module swsc_ctrl (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic [21:0]         sw_closed_i,
  input  wire logic                cs_n_i,
  input  wire logic                wake_n_i,
  input  wire logic                int_n_pin_i,
  input  wire logic                vdd_ok_i,
  input  wire logic                over_temp_i,
  input  wire logic                cmd_valid_i,
  input  wire logic [23:0]         cmd_word_i,
  input  wire swsc_pkg::swsc_cfg_s cfg_i,
  input  wire logic                int_en_i,
  output logic                     int_n_o,
  output logic                     int_n_oe_o,
  output logic [23:0]              reply_o,
  output swsc_pkg::swsc_drive_s    drive_o,
  output logic                     sleep_o
);
  import swsc_pkg::*;

  localparam int unsigned INT_BASE = `SWSC_INT_BASE_CYC;
  localparam int unsigned SCAN_BASE = `SWSC_SCAN_BASE_CYC;
  localparam int unsigned WIN_CYC = `SWSC_SCAN_WIN_CYC;
  localparam int unsigned WET_CYC = `SWSC_WET_CYC;

  // Two-flop synchronisers for the switch, select, wake, interrupt and thermal pins.
  logic [25:0] s1_q;
  logic [25:0] s2_q;
  logic [25:0] pin_raw;
  assign pin_raw = {sw_closed_i, cs_n_i, wake_n_i, int_n_pin_i, over_temp_i};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 26'h3FFFFFE;
      s2_q <= 26'h3FFFFFE;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end

  logic [21:0] sw;
  logic        cs_n;
  logic        wake_n;
  logic        intp_n;
  logic        hot;
  assign sw = s2_q[25:4];
  assign cs_n = s2_q[3];
  assign wake_n = s2_q[2];
  assign intp_n = s2_q[1];
  assign hot = s2_q[0];

  // Previous-sample copies for edge detection.
  logic [21:0] sw_prev_q;
  logic        cs_prev_q;
  logic        wake_prev_q;
  logic        intp_prev_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_prev_q   <= 22'h000000;
      cs_prev_q   <= 1'b1;
      wake_prev_q <= 1'b1;
      intp_prev_q <= 1'b1;
    end else begin
      sw_prev_q   <= sw;
      cs_prev_q   <= cs_n;
      wake_prev_q <= wake_n;
      intp_prev_q <= intp_n;
    end
  end

  // Change detection waits until real pin levels have filled the
  // synchroniser; the reset pattern would otherwise look like an event.
  logic [2:0] live_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      live_q <= 3'h0;
    end else begin
      live_q <= {live_q[1:0], 1'b1};
    end
  end

  logic        cs_rise;
  logic        cs_fall;
  logic        wake_fall;
  logic        intp_fall;
  logic [21:0] sw_chg;
  assign cs_rise = cs_n & ~cs_prev_q;
  assign cs_fall = ~cs_n & cs_prev_q;
  assign wake_fall = ~wake_n & wake_prev_q;
  assign intp_fall = ~intp_n & intp_prev_q;
  assign sw_chg = (sw ^ sw_prev_q) & ~cfg_i.tristate
                  & {22{live_q[2]}};

  // Command decode.
  logic       cmd_sleep;
  logic       cmd_status;
  logic [2:0] int_code;
  logic [2:0] scan_code;
  assign cmd_sleep = cmd_valid_i &&
                     cmd_word_i[23:16] == `SWSC_OP_SLEEP;
  assign cmd_status = cmd_valid_i &&
                      cmd_word_i[23:16] == `SWSC_OP_STATUS;
  assign int_code = cmd_word_i[`SWSC_INT_CODE_LSB +: 3];
  assign scan_code = cmd_word_i[`SWSC_SCAN_CODE_LSB +: 3];

  swsc_mode_e  mode_q;
  swsc_mode_e  mode_d;
  logic [2:0]  int_code_q;
  logic [2:0]  scan_code_q;
  logic [21:0] snap_q;
  logic [31:0] int_cnt_q;
  logic [31:0] scan_cnt_q;
  logic [31:0] int_lim;
  logic [31:0] scan_lim;
  logic        normal;

  assign normal = (mode_q == SWSC_NORMAL);
  // Periods double per code step; the shifts are cheap and exact.
  assign int_lim = INT_BASE << int_code_q;
  assign scan_lim = (SCAN_BASE << scan_code_q) >> 1;

  logic int_exp;
  logic scan_exp;
  logic win_end;
  logic scan_diff;
  assign int_exp = !normal && int_code_q != `SWSC_INT_OFF_CODE
                   && int_cnt_q == int_lim - 32'h1;
  assign scan_exp = mode_q == SWSC_SLEEP
                    && scan_code_q != `SWSC_SCAN_OFF_CODE
                    && scan_cnt_q == scan_lim - 32'h1;
  assign win_end = mode_q == SWSC_SCAN
                   && scan_cnt_q == WIN_CYC - 1;
  assign scan_diff = |((sw ^ snap_q) & cfg_i.wake_en
                       & ~cfg_i.tristate);

  // Wake sources; chip select and interrupt pin need logic supply.
  logic wake_any;
  // Floated inputs cannot show a change, so a switch wake comes only from
  // the compare at the end of a scan window.
  assign wake_any = int_exp || wake_fall
                    || (vdd_ok_i && intp_fall && wake_n)
                    || (vdd_ok_i && cs_fall)
                    || (win_end && scan_diff);

  // Mode selection.
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      SWSC_NORMAL: begin
        if (cmd_sleep) begin
          mode_d = SWSC_SLEEP;
        end
      end
      SWSC_SLEEP: begin
        if (wake_any) begin
          mode_d = SWSC_NORMAL;
        end else if (scan_exp) begin
          mode_d = SWSC_SCAN;
        end
      end
      SWSC_SCAN: begin
        if (wake_any) begin
          mode_d = SWSC_NORMAL;
        end else if (win_end) begin
          mode_d = SWSC_SLEEP;
        end
      end
      default: mode_d = SWSC_NORMAL;
    endcase
  end

  // Timers run only out of Normal and restart at sleep entry.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q      <= SWSC_NORMAL;
      int_code_q  <= 3'h7;
      scan_code_q <= 3'h0;
      snap_q      <= 22'h000000;
      int_cnt_q   <= 32'h0;
      scan_cnt_q  <= 32'h0;
    end else begin
      mode_q <= mode_d;
      if (normal && cmd_sleep) begin
        int_code_q  <= int_code;
        scan_code_q <= scan_code;
        snap_q      <= sw;
      end
      if (normal || int_exp) begin
        int_cnt_q <= 32'h0;
      end else begin
        int_cnt_q <= int_cnt_q + 32'h1;
      end
      if (normal || scan_exp || win_end) begin
        scan_cnt_q <= 32'h0;
      end else begin
        scan_cnt_q <= scan_cnt_q + 32'h1;
      end
    end
  end

  // Interrupt and thermal flags; a new event beats the clear.
  logic int_q;
  logic pend_q;
  logic therm_q;
  logic evt_q;
  logic int_set;
  logic hot_n;
  assign hot_n = normal && hot;
  assign int_set = (normal && int_en_i && |(sw_chg & cfg_i.wake_en))
                   || int_exp
                   || (win_end && scan_diff && int_en_i)
                   || (hot_n && !therm_q);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_q   <= 1'b0;
      pend_q  <= 1'b0;
      therm_q <= 1'b0;
      evt_q   <= 1'b0;
    end else begin
      if (int_set) begin
        int_q <= 1'b1;
      end else if (cs_rise && pend_q && !evt_q) begin
        int_q <= 1'b0;
      end
      // A status read in the frame arms the clear.
      if (cs_fall) begin
        pend_q <= 1'b0;
      end else if (cmd_status && !cs_n) begin
        pend_q <= 1'b1;
      end
      // Any event while selected blocks the clear, before or after the read.
      if (cs_fall) begin
        evt_q <= int_set;
      end else if (int_set && !cs_n) begin
        evt_q <= 1'b1;
      end
      if (hot_n) begin
        therm_q <= 1'b1;
      end else if (cs_rise && !hot) begin
        therm_q <= 1'b0;
      end
    end
  end

  // Wetting timers, one per input.
  logic [21:0] wet_on;
  genvar g;
  generate
    for (g = 0; g < 22; g++) begin : g_wet
      logic [17:0] wet_cnt_q;
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          wet_cnt_q <= 18'h00000;
        end else if (!sw[g]) begin
          wet_cnt_q <= 18'h00000;
        end else if (wet_cnt_q != WET_CYC[17:0]) begin
          wet_cnt_q <= wet_cnt_q + 18'h00001;
        end
      end
      assign wet_on[g] = sw[g] && (!cfg_i.wet_timer_en[g]
                         || wet_cnt_q != WET_CYC[17:0]);
    end
  endgenerate

  // Drive outputs; inputs tri-state while asleep between scans.
  logic        asleep;
  logic [21:0] high_ok;
  assign asleep = (mode_q == SWSC_SLEEP);
  // Thermal fallback drops only the 16 mA sources; settings stay intact.
  assign high_ok = cfg_i.metallic & wet_on
                   & {22{!therm_q || !hot}};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_o    <= '{high: 22'h0, low: 22'h0, tristate: 22'h3FFFFF};
      reply_o    <= 24'h000000;
      int_n_o    <= 1'b0;
      int_n_oe_o <= 1'b0;
      sleep_o    <= 1'b0;
    end else begin
      drive_o.tristate <= asleep ? 22'h3FFFFF : cfg_i.tristate;
      drive_o.high <= asleep ? 22'h0 : high_ok & ~cfg_i.tristate;
      drive_o.low  <= asleep ? 22'h0 : ~high_ok & ~cfg_i.tristate;
      reply_o <= {therm_q, int_q, sw};
      int_n_o <= 1'b0;
      int_n_oe_o <= int_q;
      sleep_o <= !normal;
    end
  end
endmodule // swsc_ctrl
`default_nettype wire

// File: tb/swsc_ctrl_props.sv
// Port checker for the sleep, wake and scan controller.
`timescale 1ns/1ns
`default_nettype none
`include "swsc_params.svh"
module swsc_ctrl_props
  import swsc_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  cs_n_i,
  input wire logic                  over_temp_i,
  input wire logic                  cmd_valid_i,
  input wire logic [23:0]           cmd_word_i,
  input wire swsc_pkg::swsc_cfg_s   cfg_i,
  input wire logic                  int_n_oe_o,
  input wire logic [23:0]           reply_o,
  input wire swsc_pkg::swsc_drive_s drive_o,
  input wire logic                  sleep_o
);
  // Repeat counts leave margin for the input synchronisers.
  wire logic sleep_cmd = cmd_valid_i && cmd_word_i[23:16] == `SWSC_OP_SLEEP;
  wire logic hot       = over_temp_i && !sleep_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sleep_entry_a:
    assert property (sleep_cmd && !sleep_o |-> ##2 sleep_o)
    else $error("Sleep command ignored.");
  sleep_cause_a:
    assert property ($rose(sleep_o) |-> $past(sleep_cmd, 2))
    else $error("Sleep without command.");
  hot_current_a:
    assert property (hot [*8] |-> drive_o.high == 22'h0)
    else $error("High current while hot.");
  hot_flag_a:
    assert property (hot [*8] |-> reply_o[23])
    else $error("Thermal flag not set.");
  flag_hot_a:
    assert property (over_temp_i [*6] |-> !$fell(reply_o[23]))
    else $error("Thermal flag cleared while hot.");
  flag_cs_a:
    assert property ($stable(cs_n_i) [*8] |-> !$fell(reply_o[23]))
    else $error("Thermal flag cleared without select.");
  int_hold_a:
    assert property ($stable(cs_n_i) [*8] |-> !$fell(int_n_oe_o))
    else $error("Interrupt dropped without a read.");
  cfg_keep_a:
    assert property (($stable(cfg_i) && !sleep_o) [*4]
      |-> drive_o.tristate == cfg_i.tristate)
    else $error("Input drive differs from settings.");
endmodule // swsc_ctrl_props

bind swsc_ctrl swsc_ctrl_props i_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
  .over_temp_i(over_temp_i), .cmd_valid_i(cmd_valid_i),
  .cmd_word_i(cmd_word_i), .cfg_i(cfg_i), .int_n_oe_o(int_n_oe_o),
  .reply_o(reply_o), .drive_o(drive_o), .sleep_o(sleep_o));
`default_nettype wire

// File: tb/swsc_ctrl_test.sv
// Self-checking bench for the sleep, wake and scan controller.
`timescale 1ns/1ns
`default_nettype none
`include "swsc_params.svh"
module swsc_ctrl_test;
  import swsc_pkg::*;
  logic        clk = 1'b0, rst_n, wake_n, ext_int;
  logic        vdd_ok, over_temp, int_en;
  logic        cs_n, cmd_valid, int_n, int_oe, sleep, ls = 1'b0, li = 1'b0;
  logic [21:0] sw;
  logic [23:0] cmd_word, reply;
  swsc_cfg_s   cfg;
  swsc_drive_s drive;
  logic        qs[$], qi[$];
  int          errors = 0, checked = 0, cycles = 0, n, b;
  localparam int WIN = `SWSC_SCAN_WIN_CYC;
  localparam int PER = `SWSC_SCAN_BASE_CYC;
  // Shared interrupt wire: pulled up unless the block or a neighbour sinks.
  wire logic   pin = !((int_oe && !int_n) || ext_int);
  always #50 clk = ~clk;
  swsc_ctrl i_dut (
    .clk_i(clk), .rst_n_i(rst_n), .sw_closed_i(sw), .cs_n_i(cs_n),
    .wake_n_i(wake_n), .int_n_pin_i(pin), .vdd_ok_i(vdd_ok),
    .over_temp_i(over_temp), .cmd_valid_i(cmd_valid), .cmd_word_i(cmd_word),
    .cfg_i(cfg), .int_en_i(int_en), .int_n_o(int_n), .int_n_oe_o(int_oe),
    .reply_o(reply), .drive_o(drive), .sleep_o(sleep));
  swsc_host_model i_host (
    .clk_i(clk), .cs_n_o(cs_n), .cmd_valid_o(cmd_valid), .cmd_word_o(cmd_word));
  task automatic check(input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic go(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic status();
    i_host.frame(`SWSC_OP_STATUS, 6'h0, 4);
  endtask
  task automatic sleep_cmd(input logic [5:0] set);
    qs.push_back(1'b1);
    i_host.frame(`SWSC_OP_SLEEP, set, 4);
  endtask
  // Counts cycles while the inputs are powered (on) or floated (not on).
  task automatic span(input logic on);
    n = 0;
    while (((drive.tristate === 22'h0) == on) && n < 12000) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Any change of sleep or interrupt state consumes the oldest note; a
  // change with no note pending counts against the block.
  always @(negedge clk) begin
    if (rst_n && sleep !== ls) begin
      check(24'(sleep), 24'(qs.size() ? qs.pop_front() : !sleep));
      ls = sleep;
    end
    if (rst_n && int_oe !== li) begin
      check(24'(int_oe), 24'(qi.size() ? qi.pop_front() : !int_oe));
      li = int_oe;
    end
  end
  // The whole run takes about 34000 cycles; the ceiling leaves slack.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n = 1'b0;
    wake_n = 1'b1;
    ext_int = 1'b0;
    vdd_ok = 1'b1;
    over_temp = 1'b0;
    int_en = 1'b1;
    void'($urandom(32'hB459));
    sw = 22'($urandom);
    cfg = '{wake_en: 22'h3FFFFF, metallic: 22'($urandom),
            wet_timer_en: 22'($urandom), tristate: 22'h0};
    go(8);
    rst_n = 1'b1;
    go(10);
    // A change holds the interrupt until a status read, which also reports
    // the switch levels.
    sw[$urandom_range(21)] ^= 1'b1;
    qi.push_back(1'b1);
    go(40);
    qi.push_back(1'b0);
    status();
    check(24'(reply[21:0]), 24'(sw));
    // A change inside the reading frame keeps the interrupt past deselect.
    sw[$urandom_range(21)] ^= 1'b1;
    qi.push_back(1'b1);
    go(10);
    fork
      status();
      begin go(7); sw[$urandom_range(21)] ^= 1'b1; end
    join
    go(20);
    qi.push_back(1'b0);
    status();
    // Interrupts off: a slow polling read still sees the new level.
    int_en = 1'b0;
    sw[0] = ~sw[0];
    go(10);
    i_host.frame(`SWSC_OP_STATUS, 6'h0, 12);
    check(24'(reply[21:0]), 24'(sw));
    int_en = 1'b1;
    // A floated input and one kept from waking raise nothing; the drive
    // follows the settings and closed metallic inputs get the high current.
    b = $urandom_range(20);
    cfg.tristate[b] = 1'b1;
    cfg.wake_en[b + 1] = 1'b0;
    go(5);
    sw[b] = ~sw[b];
    sw[b + 1] = ~sw[b + 1];
    go(20);
    check(24'(drive.tristate), 24'(cfg.tristate));
    check(24'(drive.high), 24'(sw & cfg.metallic & ~cfg.tristate));
    cfg.tristate[b] = 1'b0;
    cfg.wake_en[b + 1] = 1'b1;
    go(5);
    // Sleep with the shortest scan: heat is ignored, then window and period.
    sleep_cmd(6'h39);
    over_temp = 1'b1;
    go(200);
    over_temp = 1'b0;
    span(1'b0);
    span(1'b1);
    check(24'(n > WIN - 3 && n < WIN + 3), 24'h1);
    span(1'b0);
    check(24'(n > PER - 3 && n < PER + 3), 24'h1);
    sw[$urandom_range(21)] ^= 1'b1;
    qs.push_back(1'b0);
    qi.push_back(1'b1);
    go(12000);
    qi.push_back(1'b0);
    status();
    // Each pin wake source in turn; select alone cannot wake without supply.
    for (int k = 0; k < 4; k++) begin
      sleep_cmd(6'h38);
      go(20);
      vdd_ok = (k != 3);
      qs.push_back(1'b0);
      case (k)
        0: status(); // first reply after this wake is not used
        1: begin wake_n = 1'b0; go(5); wake_n = 1'b1; end
        2: begin ext_int = 1'b1; go(5); ext_int = 1'b0; end
        default: begin
          status();
          check(24'(sleep), 24'h1);
          wake_n = 1'b0;
          go(5);
          wake_n = 1'b1;
        end
      endcase
      go(20);
      vdd_ok = 1'b1;
    end
    // Heat forces low current; the flag clears only at a deselect once cool.
    over_temp = 1'b1;
    qi.push_back(1'b1);
    go(30);
    check(24'(drive.high), 24'h0);
    check(24'(drive.low), 24'h3FFFFF);
    over_temp = 1'b0;
    go(30);
    qi.push_back(1'b0);
    status();
    status();
    check(24'(reply[23]), 24'h0);
    tally_and_finish();
  end
endmodule // swsc_ctrl_test
`default_nettype wire

// File: tb/swsc_host_model.sv
// Host controller model that frames command words towards the block.
`timescale 1ns/1ns
`default_nettype none
module swsc_host_model (
  input  wire logic        clk_i,
  output var  logic        cs_n_o,
  output var  logic        cmd_valid_o,
  output var  logic [23:0] cmd_word_o
);
  // Select idles high; the word bus starts from a neutral value.
  initial begin
    cs_n_o = 1'b1;
    cmd_valid_o = 1'b0;
    cmd_word_o = 24'h0;
  end
  // One frame with a chosen lag before the word. Once the word is taken the
  // bus shows its inverse, so nothing can lean on a stale command.
  task automatic frame(input logic [7:0] op, input logic [5:0] set,
                       input int lag);
    logic [23:0] w;
    w = {op, 10'($urandom), set};
    @(negedge clk_i) cs_n_o = 1'b0;
    repeat (lag) @(negedge clk_i);
    cmd_word_o = w;
    cmd_valid_o = 1'b1;
    @(negedge clk_i) cmd_valid_o = 1'b0;
    cmd_word_o = ~w;
    repeat (8) @(negedge clk_i);
    cs_n_o = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
endmodule // swsc_host_model
`default_nettype wire
